//--- dv/prb_mem_model.sv
// memory side model: accepts record writes after a programmable wait
`timescale 1ns/1ps

module prb_mem_model (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic rec_req_i,
  input wire logic [31:0] rec_addr_i,
  input wire logic [63:0] rec_data_i,
  input wire logic [3:0] delay_i,
  input wire logic avail_i,
  output logic rec_ack_o,
  output logic mem_ready_o,
  output logic [31:0] last_addr_o,
  output logic [63:0] last_data_o,
  output logic [15:0] n_wr_o
);
  logic [3:0] wait_cnt;

  // buffer pages can be absent; the bench decides when
  assign mem_ready_o = avail_i;

  // ack one cycle per request; keeps the last address and data and counts the writes
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      rec_ack_o <= 1'b0;
      wait_cnt <= 4'h0;
      last_addr_o <= 32'h0;
      last_data_o <= 64'h0;
      n_wr_o <= 16'h0;
    end
    else if (rec_req_i && !rec_ack_o && wait_cnt >= delay_i)
    begin
      rec_ack_o <= 1'b1;
      wait_cnt <= 4'h0;
      last_addr_o <= rec_addr_i;
      last_data_o <= rec_data_i;
      n_wr_o <= n_wr_o + 16'h1;
    end
    else
    begin
      rec_ack_o <= 1'b0;
      wait_cnt <= (rec_req_i && !rec_ack_o) ? wait_cnt + 4'h1 : 4'h0;
    end
  end
endmodule : prb_mem_model

//--- dv/tb_top.sv
// self-checking bench for the profiling record ring buffer
`timescale 1ns/1ps
`include "prb_params.svh"

module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, retire = 1'b0, abort = 1'b0, avail = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF, hit = 4'h0, dly = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, rd, raddr, m_addr;
  logic [55:0] iaddr = 56'h0;
  logic [63:0] rrec, m_data;
  logic ack, req, rack, ready, irq;
  logic [15:0] n_wr, exp_wr = 16'h0;
  int n_errors = 0;
  int n_compared = 0;

  // ----------------------------------------------------------------
  // clock, design and memory side
  // ----------------------------------------------------------------
  always #2 clk = ~clk;

  prb_ring i_prb_ring (.ref_clk_i(clk), .sys_rst_i(rst), .ce_i(1'b1), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .retire_i(retire), .ev_hit_i(hit),
    .instr_addr_i(iaddr), .replay_abort_i(abort), .mem_ready_i(ready), .rec_req_o(req),
    .rec_addr_o(raddr), .rec_data_o(rrec), .rec_ack_i(rack), .irq_o(irq));

  prb_mem_model i_prb_mem_model (.ref_clk_i(clk), .sys_rst_i(rst), .rec_req_i(req),
    .rec_addr_i(raddr), .rec_data_i(rrec), .delay_i(dly), .avail_i(avail),
    .rec_ack_o(rack), .mem_ready_o(ready), .last_addr_o(m_addr), .last_data_o(m_data),
    .n_wr_o(n_wr));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  // classic cycle: hold until ack is sampled high, take data at that edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do @(posedge clk); while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 4'hF);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0, 4'hF);
    cmp(rd, exp);
  endtask : rdc

  // n retiring cycles with hit mask m, then wait until the store sequence is idle
  task automatic hits(input logic [3:0] m, input int n, input logic [55:0] a);
    @(posedge clk);
    retire <= 1'b1;
    hit <= m;
    iaddr <= a;
    repeat (n) @(posedge clk);
    retire <= 1'b0;
    hit <= 4'h0;
    do wb(1'b0, `PRB_OFS_STATUS, 32'h0, 4'hF); while (rd[`PRB_ST_BUSY] !== 1'b0);
  endtask : hits

  task automatic rec(input logic [31:0] a, input logic [63:0] d);
    exp_wr = exp_wr + 16'h1;
    cmp(n_wr, exp_wr);
    cmp(m_addr, a);
    cmp(m_data, d);
  endtask : rec

  task automatic wrap_up;
    $display("mismatches %0d of %0d compared", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : wrap_up

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  // watchdog: the sequence needs a few hundred cycles
  initial
  begin
    #80000;
    n_errors++;
    wrap_up;
  end

  // main sequence
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rdc(`PRB_OFS_CTRL, 32'h0);
    rdc(`PRB_OFS_SIZE, 32'h10);
    rdc(`PRB_OFS_IVAL0, 32'h100);
    rdc(`PRB_OFS_MIN_IVAL, 32'h10);
    rdc(`PRB_OFS_HEAD, 32'h0);
    wb(1'b1, `PRB_OFS_SIZE, 32'h4, 4'h3);
    rdc(`PRB_OFS_SIZE, 32'h10);
    wr(8'hFC, 32'hFFFF_FFFF);
    rdc(8'hFC, 32'h0);
    wr(`PRB_OFS_IVAL0 + 8'h04, 32'h4);
    rdc(`PRB_OFS_IVAL0 + 8'h04, 32'h10);
    wr(`PRB_OFS_IVAL0, 32'h0);
    rdc(`PRB_OFS_IVAL0, 32'h0);
    wr(`PRB_OFS_BASE, 32'h1000);
    wr(`PRB_OFS_SIZE, 32'h4);
    wr(`PRB_OFS_THRESH, 32'h2);
    wr(`PRB_OFS_TAIL, 32'h0);
    wr(`PRB_OFS_CTRL, 32'h5);
    // counter starts at the interval: hit 17 records, three more decrement before reload
    hits(4'h2, 20, 56'h11);
    rec(32'h1000, {8'h02, 56'h11});
    hits(4'h2, 13, 56'h22);
    cmp(n_wr, exp_wr);
    hits(4'h2, 1, 56'h33);
    rec(32'h1020, {8'h02, 56'h33});
    hits(4'h1, 1, 56'h44);
    rec(32'h1040, {8'h01, 56'h44});
    hits(4'h1, 1, 56'h55);
    cmp(n_wr, exp_wr);
    rdc(`PRB_OFS_HEAD, 32'h3);
    rdc(`PRB_OFS_MISS_LO, 32'h1);
    rdc(`PRB_OFS_MISS_HI, 32'h0);
    cmp(irq, 1'b1);
    wr(`PRB_OFS_TAIL, 32'h2);
    hits(4'h1, 1, 56'h66);
    rec(32'h1060, {8'h01, 56'h66});
    rdc(`PRB_OFS_HEAD, 32'h0);
    cmp(irq, 1'b0);
    // memory absent, then aborted replay: both drop, next hit records
    avail <= 1'b0;
    hits(4'h1, 1, 56'h77);
    cmp(n_wr, exp_wr);
    avail <= 1'b1;
    abort <= 1'b1;
    hits(4'h1, 1, 56'h78);
    cmp(n_wr, exp_wr);
    abort <= 1'b0;
    dly <= 4'h3;
    hits(4'h1, 1, 56'h88);
    rec(32'h1000, {8'h01, 56'h88});
    // continuous mode from a clean buffer
    wr(`PRB_OFS_CTRL, 32'h0);
    wr(`PRB_OFS_CTRL, 32'h10);
    wr(`PRB_OFS_MISS_LO, 32'h0);
    wr(`PRB_OFS_MISS_HI, 32'h0);
    wr(`PRB_OFS_TAIL, 32'h0);
    wr(`PRB_OFS_CTRL, 32'h3);
    rdc(`PRB_OFS_STATUS, 32'h9);
    for (int i = 0; i < 4; i++)
    begin
      hits(4'h1, 1, 56'(i));
      rec(32'(32'h1000 + 32 * i), {8'h01, 56'(i)});
    end
    wr(`PRB_OFS_CTRL, 32'h0);
    rdc(`PRB_OFS_HEAD, 32'h0);
    rdc(`PRB_OFS_MISS_LO, 32'h1);
    wrap_up;
  end
endmodule : tb_top

//--- logic/prb_lfsr.sv
// pseudo random source for interval randomization
`timescale 1ns/1ps
`include "prb_params.svh"

module prb_lfsr (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  output logic [15:0] rnd_o
);

  // galois lfsr, steps every enabled cycle so draws look uncorrelated
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      rnd_o <= `PRB_LFSR_SEED;
    else if (ce_i)
      rnd_o <= {1'b0, rnd_o[15:1]} ^ (rnd_o[0] ? 16'hB400 : 16'h0000);
  end

endmodule : prb_lfsr

//--- logic/prb_params.svh
// constants for the profiling record ring buffer: sizes, offsets, fields, reset values
`ifndef PRB_PARAMS_SVH
`define PRB_PARAMS_SVH

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define PRB_NUM_EV 4
`define PRB_EV_W 2
`define PRB_IDX_W 16
`define PRB_IADDR_W 56
`define PRB_REC_SHIFT 5
`define PRB_RAND_BITS 4

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define PRB_OFS_CTRL 8'h00
`define PRB_OFS_STATUS 8'h04
`define PRB_OFS_BASE 8'h08
`define PRB_OFS_SIZE 8'h0C
`define PRB_OFS_HEAD 8'h10
`define PRB_OFS_TAIL 8'h14
`define PRB_OFS_THRESH 8'h18
`define PRB_OFS_MISS_LO 8'h1C
`define PRB_OFS_MISS_HI 8'h20
`define PRB_OFS_MIN_IVAL 8'h24
`define PRB_OFS_IVAL0 8'h40

// ----------------------------------------------------------------
// control and status fields
// ----------------------------------------------------------------
`define PRB_CTRL_RUN 0
`define PRB_CTRL_CONT 1
`define PRB_CTRL_INT_EN 2
`define PRB_CTRL_RAND 3
`define PRB_CTRL_CLR 4
`define PRB_ST_RUNNING 0
`define PRB_ST_IRQ 1
`define PRB_ST_BUSY 2
`define PRB_ST_CONT 3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PRB_RST_SIZE 16'h0010
`define PRB_RST_IVAL 32'h0000_0100
`define PRB_RST_MIN 32'h0000_0010
`define PRB_LFSR_SEED 16'hACE1

`endif

//--- logic/prb_pkg.sv
// types shared by the profiling record ring buffer
package prb_pkg;

  // store sequence states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_GATHER,
    ST_CHECK,
    ST_REFRESH,
    ST_WRITE,
    ST_RELOAD
  } prb_state_e;

endpackage : prb_pkg

//--- logic/prb_ring.sv
// profiling event counters, record gather, ring store and wishbone registers
//
// The address map and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
`include "prb_params.svh"

// What this block does
// - retire decrements counters; negative triggers gather
// - mode flag 0 sync, 1 continuous
// - several eligible: record one, others wait
// - memory unavailable: drop, recapture next event
// - aborted replay: keep counting, recapture next
// - write record at head, then advance head
// - full when head plus one equals tail
// - full buffer bumps 64-bit missed count
// - sync mode: full keeps head, record lost
// - continuous mode: advance anyway, count wraps
// - simultaneous stores: store one at a time
// - late store still holds captured data
// - occupancy above threshold raises interrupt
// - reload interval, optional random low bits
// - reload on head advance or missed count
// - overrun below -1 reduces reload
// - enforce minimum interval, visible in fields
// - never write tail or application region
// - stale tail: re-read and recheck first
module prb_ring (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic retire_i,
  input wire logic [`PRB_NUM_EV-1:0] ev_hit_i,
  input wire logic [`PRB_IADDR_W-1:0] instr_addr_i,
  input wire logic replay_abort_i,
  input wire logic mem_ready_i,
  output logic rec_req_o,
  output logic [31:0] rec_addr_o,
  output logic [63:0] rec_data_o,
  input wire logic rec_ack_i,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  prb_pkg::prb_state_e st;
  logic run, cont, int_en, rand_en, refreshed, tail_ok;
  logic [31:0] base, thresh, min_ival;
  logic [`PRB_IDX_W-1:0] size, head, tail, tail_cache;
  logic [63:0] missed;
  logic [31:0] ival [`PRB_NUM_EV];
  logic signed [31:0] cnt [`PRB_NUM_EV];
  logic [`PRB_EV_W-1:0] sel_ev;
  logic [`PRB_NUM_EV-1:0] elig, dec;
  logic [15:0] rnd;

  prb_lfsr u_lfsr (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .rnd_o(rnd)
  );

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire bus_wr = bus_req & wb_we_i & (&wb_sel_i);
  wire wr_ctrl = bus_wr & (wb_adr_i == `PRB_OFS_CTRL);
  wire wr_miss_lo = bus_wr & (wb_adr_i == `PRB_OFS_MISS_LO);
  wire wr_miss_hi = bus_wr & (wb_adr_i == `PRB_OFS_MISS_HI);
  wire run_rise = wr_ctrl & wb_dat_i[`PRB_CTRL_RUN] & ~run;
  wire [`PRB_EV_W-1:0] ival_sel = wb_adr_i[`PRB_EV_W+1:2];
  wire in_ival = (wb_adr_i[7:4] == 4'(`PRB_OFS_IVAL0 >> 4));
  wire wr_ival = bus_wr & in_ival;
  // enforced minimum applies to all but the value sample event
  wire [31:0] ival_wr = (ival_sel != '0 && wb_dat_i < min_ival) ? min_ival : wb_dat_i;

  // ----------------------------------------------------------------
  // ring arithmetic
  // ----------------------------------------------------------------
  wire [`PRB_IDX_W-1:0] head_next = (head == size - 16'h0001) ? '0 : head + 16'h0001;
  wire full_c = (head_next == tail_cache);
  wire [`PRB_IDX_W-1:0] occ = (head >= tail_cache) ? head - tail_cache
                                                   : head + size - tail_cache;
  wire thr_sus = int_en & run & ({16'h0000, occ} > thresh);
  wire any_elig = |elig;
  wire [`PRB_EV_W-1:0] pick;
  wire [31:0] rec_addr_n = base + {11'h000, head, 5'h00};

  // lowest index wins when several counters are eligible together
  function automatic logic [`PRB_EV_W-1:0] first_one(input logic [`PRB_NUM_EV-1:0] v);
    logic [`PRB_EV_W-1:0] r;
    r = '0;
    for (int k = `PRB_NUM_EV - 1; k >= 0; k--)
      if (v[k])
        r = k[`PRB_EV_W-1:0];
    return r;
  endfunction : first_one
  assign pick = first_one(elig);

  // ----------------------------------------------------------------
  // reload value for the selected event
  // ----------------------------------------------------------------
  wire [31:0] ival_s = ival[sel_ev];
  wire [31:0] ival_min = (sel_ev != '0 && ival_s < min_ival) ? min_ival : ival_s;
  wire [31:0] ival_r = rand_en ? {ival_min[31:`PRB_RAND_BITS],
                                  ival_min[`PRB_RAND_BITS-1:0] ^ rnd[`PRB_RAND_BITS-1:0]}
                               : ival_min;
  wire signed [31:0] cnt_s = cnt[sel_ev];
  // overrun past -1 is folded back so the sample spacing stays unbiased
  wire [31:0] reload_val = (cnt_s < -32'sd1) ? ival_r + 32'(cnt_s) + 32'h0000_0001
                                            : ival_r;
  wire do_reload = (st == prb_pkg::ST_RELOAD);

  // ----------------------------------------------------------------
  // per event counters
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `PRB_NUM_EV; g++)
    begin : g_ev
      assign dec[g] = run & retire_i & ev_hit_i[g];
      // reaches negative on this instruction, or is already negative
      assign elig[g] = dec[g] & (cnt[g] <= 32'sd0);
      wire rl = do_reload & (sel_ev == g);
      always_ff @(posedge ref_clk_i or posedge sys_rst_i)
      begin
        if (sys_rst_i)
          cnt[g] <= 32'sd0;
        else if (ce_i)
        begin
          if (run_rise)
            cnt[g] <= $signed(ival[g]);
          else if (rl)
            cnt[g] <= $signed(reload_val - {31'h0, dec[g]});
          else if (dec[g])
            cnt[g] <= cnt[g] - 32'sd1;
        end
      end
      always_ff @(posedge ref_clk_i or posedge sys_rst_i)
      begin
        if (sys_rst_i)
          ival[g] <= `PRB_RST_IVAL;
        else if (ce_i && wr_ival && ival_sel == g)
          ival[g] <= ival_wr;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  // mode is latched only when profiling starts
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      run <= 1'b0;
      cont <= 1'b0;
      int_en <= 1'b0;
      rand_en <= 1'b0;
    end
    else if (ce_i && wr_ctrl)
    begin
      run <= wb_dat_i[`PRB_CTRL_RUN];
      int_en <= wb_dat_i[`PRB_CTRL_INT_EN];
      rand_en <= wb_dat_i[`PRB_CTRL_RAND];
      if (run_rise)
        cont <= wb_dat_i[`PRB_CTRL_CONT];
    end
  end

  // ring geometry and software owned tail
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      base <= '0;
      size <= `PRB_RST_SIZE;
      tail <= '0;
      thresh <= '0;
      min_ival <= `PRB_RST_MIN;
    end
    else if (ce_i && bus_wr)
    begin
      case (wb_adr_i)
        `PRB_OFS_BASE: base <= wb_dat_i;
        `PRB_OFS_SIZE: size <= wb_dat_i[`PRB_IDX_W-1:0];
        `PRB_OFS_TAIL: tail <= wb_dat_i[`PRB_IDX_W-1:0];
        `PRB_OFS_THRESH: thresh <= wb_dat_i;
        `PRB_OFS_MIN_IVAL: min_ival <= wb_dat_i;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // store sequence
  // ----------------------------------------------------------------
  wire write_done = (st == prb_pkg::ST_WRITE) & rec_ack_i;
  wire miss_inc = (st == prb_pkg::ST_CHECK & full_c & refreshed & ~cont)
                | (write_done & full_c);
  // an increment in the same cycle as a software write is applied on top of it
  wire [63:0] miss_base = wr_miss_lo ? {missed[63:32], wb_dat_i}
                        : wr_miss_hi ? {wb_dat_i, missed[31:0]} : missed;
  wire [63:0] next_missed = miss_base + {63'h0, miss_inc};

  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      missed <= '0;
    else if (ce_i)
      missed <= next_missed;
  end

  // head only advances after the record landed; tail is never written here
  // a record landing in the same cycle as a clear wins, so no stored record is orphaned
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      head <= '0;
    else if (ce_i)
    begin
      if (write_done)
        head <= head_next;
      else if (wr_ctrl && wb_dat_i[`PRB_CTRL_CLR] && !run)
        head <= '0;
    end
  end

  // record capture and the walk through check, write and reload
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      st <= prb_pkg::ST_IDLE;
      sel_ev <= '0;
      refreshed <= 1'b0;
      rec_req_o <= 1'b0;
      rec_addr_o <= '0;
      rec_data_o <= '0;
    end
    else if (ce_i)
    begin
      case (st)
        prb_pkg::ST_IDLE:
          if (run && any_elig)
          begin
            sel_ev <= pick;
            rec_data_o <= {5'h00, {1'b0, pick} + 3'h1, instr_addr_i};
            st <= prb_pkg::ST_GATHER;
          end
        prb_pkg::ST_GATHER:
        begin
          refreshed <= 1'b0;
          st <= replay_abort_i ? prb_pkg::ST_IDLE : prb_pkg::ST_CHECK;
        end
        prb_pkg::ST_CHECK:
          if (full_c && !refreshed)
            st <= prb_pkg::ST_REFRESH;
          else if (full_c && !cont)
            st <= prb_pkg::ST_RELOAD;
          else if (!mem_ready_i)
            st <= prb_pkg::ST_IDLE;
          else
          begin
            rec_req_o <= 1'b1;
            rec_addr_o <= rec_addr_n;
            st <= prb_pkg::ST_WRITE;
          end
        prb_pkg::ST_REFRESH:
        begin
          refreshed <= 1'b1;
          st <= prb_pkg::ST_CHECK;
        end
        prb_pkg::ST_WRITE:
          if (rec_ack_i)
          begin
            rec_req_o <= 1'b0;
            st <= prb_pkg::ST_RELOAD;
          end
        prb_pkg::ST_RELOAD:
          st <= prb_pkg::ST_IDLE;
        default:
          st <= prb_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // tail cache and threshold report
  // ----------------------------------------------------------------
  // the cache is refreshed when profiling starts and when it hints at full or threshold
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      tail_cache <= '0;
      tail_ok <= 1'b0;
      irq_o <= 1'b0;
    end
    else if (ce_i)
    begin
      if (st == prb_pkg::ST_REFRESH || (thr_sus && !tail_ok) || run_rise)
        tail_cache <= tail;
      tail_ok <= (tail_cache == tail);
      irq_o <= thr_sus & tail_ok & (tail_cache == tail);
    end
  end

  // ----------------------------------------------------------------
  // wishbone slave: ack one cycle after strobe, unmapped reads zero
  // ----------------------------------------------------------------
  wire [31:0] status = {28'h0, cont, st != prb_pkg::ST_IDLE, irq_o, run};
  wire [31:0] rd_mux = (wb_adr_i == `PRB_OFS_CTRL) ? {27'h0, 1'b0, rand_en, int_en, cont, run}
                     : (wb_adr_i == `PRB_OFS_STATUS) ? status
                     : (wb_adr_i == `PRB_OFS_BASE) ? base
                     : (wb_adr_i == `PRB_OFS_SIZE) ? {16'h0, size}
                     : (wb_adr_i == `PRB_OFS_HEAD) ? {16'h0, head}
                     : (wb_adr_i == `PRB_OFS_TAIL) ? {16'h0, tail}
                     : (wb_adr_i == `PRB_OFS_THRESH) ? thresh
                     : (wb_adr_i == `PRB_OFS_MISS_LO) ? missed[31:0]
                     : (wb_adr_i == `PRB_OFS_MISS_HI) ? missed[63:32]
                     : (wb_adr_i == `PRB_OFS_MIN_IVAL) ? min_ival
                     : in_ival ? ival[ival_sel]
                     : 32'h0000_0000;

  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end
    else if (ce_i)
    begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? rd_mux : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  chk_head_after_ack: assert property (
    ce_i && write_done |=> head == $past(head_next))
    else $error("head did not advance after record write");
  chk_sync_full_hold: assert property (
    ce_i && st == prb_pkg::ST_CHECK && full_c && refreshed && !cont
      |=> $stable(head) && st == prb_pkg::ST_RELOAD)
    else $error("sync mode full buffer moved head");
  chk_miss_count_inc: assert property (
    ce_i && miss_inc && !wr_miss_lo && !wr_miss_hi |=> missed == $past(missed) + 64'h1)
    else $error("missed count not incremented");
  chk_refresh_first: assert property (
    ce_i && st == prb_pkg::ST_CHECK && full_c && !refreshed |=> st == prb_pkg::ST_REFRESH)
    else $error("full acted on without tail refresh");
  chk_head_wraps: assert property (
    ce_i && write_done && head == size - 16'h0001 |=> head == '0)
    else $error("head did not wrap");
  chk_abort_drops: assert property (
    ce_i && st == prb_pkg::ST_GATHER && replay_abort_i |=> st == prb_pkg::ST_IDLE)
    else $error("aborted replay still stored");
  chk_no_mem_drop: assert property (
    ce_i && st == prb_pkg::ST_CHECK && (!full_c || refreshed) && (!full_c || cont)
      && !mem_ready_i |=> st == prb_pkg::ST_IDLE && !rec_req_o)
    else $error("record written while memory unavailable");
  chk_reload_value: assert property (
    ce_i && do_reload && !dec[sel_ev] && !run_rise |=> cnt[$past(sel_ev)] == $signed($past(reload_val)))
    else $error("counter not reloaded");
  chk_rec_stable: assert property (
    rec_req_o && !rec_ack_i |=> $stable(rec_data_o) && $stable(rec_addr_o))
    else $error("record changed during store");
  chk_irq_cause: assert property (
    irq_o |-> int_en || $past(int_en))
    else $error("interrupt without enable");

  cov_store: cover property (write_done);
  cov_sync_full: cover property (st == prb_pkg::ST_CHECK && full_c && refreshed && !cont);
  cov_cont_wrap: cover property (write_done && full_c && cont);
  cov_irq: cover property ($rose(irq_o));

endmodule : prb_ring
